// >>> mpwm_top.sv
// Three-phase PWM drive with run, direction, speed and trips.
// Assumes all pins and converter codes are synchronous to sys_clk
// and that the codes are refreshed by an external sampler.
// Notes on behaviour
// - Run input on starts drive at setpoint speed
// - Run input off forces all six gates off
// - Direction high is forward, low is reverse
// - Forward fires U,V,W; reverse fires W,V,U
// - Higher setpoint gives larger duty ratio
// - Run only when setpoint reaches 0.4 V
// - Carrier frequency between 15 and 16 kHz
// - Two microsecond dead time both edge directions
// - Over-voltage trips above 440, releases below 380
// - Short-circuit trips above 2.0 A
// - Current above 1.5 A ends pulse this cycle
// - Over-temperature trips at 100 degrees
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
module mpwm_top
    import mpwm_pkg::*;
#(
    parameter int unsigned PERIOD = PWM_PERIOD_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic run_input_pin,
    input wire logic direction_input_pin,
    input wire logic [ADC_W-1:0] speed_sense_channel,
    input wire logic [11:0] bus_volt_code,
    input wire logic [11:0] phase_current_code,
    input wire logic [11:0] module_temp_code,
    output mpwm_gate_type gate,
    output logic fault_flag,
    output logic irq
);

    localparam int unsigned CW = $clog2(PERIOD);
    localparam int PERIOD_LAST = PERIOD - 1;

    // Carrier and duty
    logic [CW-1:0] cnt;              // Carrier position
    logic [CW-1:0] next_cnt;
    logic [CW-1:0] duty;             // Compare value this period
    logic [CW-1:0] next_duty;
    logic [ADC_W+CW-1:0] duty_prod;  // Setpoint times period
    logic period_start;
    logic cut;                       // Pulse ended by current limit
    logic next_cut;
    logic cbc_over;
    logic pwm_on;

    // Commutation
    logic [15:0] step_cnt;           // Periods spent in this step
    logic [15:0] next_step_cnt;
    logic [1:0] step;                // Active phase index
    logic [1:0] next_step;
    logic step_adv;

    // Trips and drive state
    logic ov_trip;                   // Over-voltage, hysteretic
    logic next_ov;
    logic sc_trip;                   // Short circuit, latched
    logic next_sc;
    logic ot_trip;                   // Over-temperature, level
    logic next_ot;
    logic fault_now;
    logic run_ok;
    mpwm_state_type state;
    mpwm_state_type next_state;
    logic next_fault_flag;

    // Register file and bus
    logic drive_enable;              // Software run permission
    logic [15:0] step_div;
    logic [3:0] irq_sts;
    logic [3:0] irq_mask;
    logic next_drive_enable;
    logic [15:0] next_step_div;
    logic [3:0] next_irq_sts;
    logic [3:0] next_irq_mask;
    logic [3:0] irq_ev;
    logic next_irq;
    logic next_wait;
    logic [31:0] next_rdata;
    logic [31:0] lane;               // Byte enables as a bit mask
    logic wr_fire;
    logic [2:0] drive_en;

    // Carrier counter sets the period in clocks
    assign period_start = (cnt == CW'(PERIOD_LAST));
    assign duty_prod = speed_sense_channel * CW'(PERIOD);
    assign cbc_over = (phase_current_code > CBC_CODE);
    assign pwm_on = (cnt < duty) && !cut && !cbc_over;

    always_comb begin
        next_cnt = period_start ? '0 : cnt + CW'(1);
        // Duty scales with the setpoint, updated once per period
        next_duty = period_start ? duty_prod[ADC_W+CW-1:ADC_W] : duty;
        // Limit holds to period end; a new over still wins then
        next_cut = period_start ? cbc_over : (cut || cbc_over);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cnt <= '0;
            duty <= '0;
            cut <= 1'b0;
        end else begin
            cnt <= next_cnt;
            duty <= next_duty;
            cut <= next_cut;
        end
    end

    // Step through the phases; direction picks the order
    assign step_adv = period_start && (step_cnt >= step_div);
    always_comb begin
        next_step_cnt = step_adv ? 16'h0000
                      : (period_start ? step_cnt + 16'h0001 : step_cnt);
        next_step = step;
        if (step_adv) begin
            if (direction_input_pin) begin
                next_step = (step == 2'h2) ? 2'h0 : step + 2'h1;
            end else begin
                next_step = (step == 2'h0) ? 2'h2 : step - 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            step_cnt <= '0;
            step <= 2'h0;
        end else begin
            step_cnt <= next_step_cnt;
            step <= next_step;
        end
    end

    // Protection trips and the drive state machine
    assign run_ok = run_input_pin && drive_enable &&
                    (speed_sense_channel >= RUN_CODE);
    always_comb begin
        next_ov = ov_trip;
        if (bus_volt_code > OV_TRIP_CODE) begin
            next_ov = 1'b1;
        end else if (bus_volt_code < OV_RELEASE_CODE) begin
            next_ov = 1'b0;
        end
        // Short circuit stays until the run input is turned off
        next_sc = (phase_current_code > SC_CODE) ||
                  (sc_trip && run_input_pin);
        next_ot = (module_temp_code >= OT_CODE);
        fault_now = ov_trip || sc_trip || ot_trip;
        next_fault_flag = fault_now;
        case (state)
            ST_STOP: next_state = fault_now ? ST_FAULT
                                : (run_ok ? ST_RUN : ST_STOP);
            ST_RUN: next_state = fault_now ? ST_FAULT
                               : (run_ok ? ST_RUN : ST_STOP);
            ST_FAULT: next_state = fault_now ? ST_FAULT : ST_STOP;
            default: next_state = ST_STOP;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ov_trip <= 1'b0;
            sc_trip <= 1'b0;
            ot_trip <= 1'b0;
            state <= ST_STOP;
            fault_flag <= 1'b0;
        end else begin
            ov_trip <= next_ov;
            sc_trip <= next_sc;
            ot_trip <= next_ot;
            state <= next_state;
            fault_flag <= next_fault_flag;
        end
    end

    // Only the active phase conducts, and only while running
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_leg
            assign drive_en[gi] = (state == ST_RUN) &&
                                  (step == 2'(gi));
            mpwm_phase #(
                .DEAD(DEAD_CYC)
            ) u_leg (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .drive_en(drive_en[gi]),
                .pwm_on(pwm_on),
                .hs(gate.hs[gi]),
                .ls(gate.ls[gi])
            );
        end
    endgenerate

    // Avalon slave: one wait cycle, then the access completes.
    // Read data is prepared in the wait cycle so it stands on time.
    assign wr_fire = avs_write && !avs_waitrequest;
    assign lane = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign irq_ev = {cbc_over && !cut, next_ot && !ot_trip,
                     next_sc && !sc_trip, next_ov && !ov_trip};

    always_comb begin
        next_wait = !((avs_read || avs_write) && avs_waitrequest);
        next_drive_enable = drive_enable;
        next_step_div = step_div;
        next_irq_mask = irq_mask;
        next_irq_sts = irq_sts;
        if (wr_fire) begin
            case (avs_address)
                REG_CTRL: begin
                    if (avs_byteenable[0]) begin
                        next_drive_enable = avs_writedata[0];
                    end
                end
                REG_IRQ_STS: begin
                    next_irq_sts = irq_sts & ~(avs_writedata[3:0] & lane[3:0]);
                end
                REG_IRQ_MASK: begin
                    next_irq_mask = (irq_mask & ~lane[3:0]) |
                                    (avs_writedata[3:0] & lane[3:0]);
                end
                REG_STEP_DIV: begin
                    next_step_div = (step_div & ~lane[15:0]) |
                                    (avs_writedata[15:0] & lane[15:0]);
                end
                default: begin
                end
            endcase
        end
        // New events win over a clear in the same cycle
        next_irq_sts = next_irq_sts | irq_ev;
        next_irq = |(irq_sts & irq_mask);
        next_rdata = avs_readdata;
        if (avs_read && avs_waitrequest) begin
            case (avs_address)
                REG_CTRL: next_rdata = {31'h0, drive_enable};
                REG_STATUS: next_rdata = {24'h0, step, state,
                                          fault_flag, direction_input_pin,
                                          run_input_pin};
                REG_IRQ_STS: next_rdata = {28'h0, irq_sts};
                REG_IRQ_MASK: next_rdata = {28'h0, irq_mask};
                REG_STEP_DIV: next_rdata = {16'h0, step_div};
                REG_DUTY: next_rdata = 32'(duty);
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            drive_enable <= CTRL_RST[0];
            step_div <= STEP_DIV_RST;
            irq_mask <= IRQ_MASK_RST;
            irq_sts <= 4'h0;
            irq <= 1'b0;
        end else begin
            avs_waitrequest <= next_wait;
            avs_readdata <= next_rdata;
            drive_enable <= next_drive_enable;
            step_div <= next_step_div;
            irq_mask <= next_irq_mask;
            irq_sts <= next_irq_sts;
            irq <= next_irq;
        end
    end

    sequence s_step_fwd;
        step_adv && direction_input_pin;
    endsequence
    sequence s_step_rev;
        step_adv && !direction_input_pin;
    endsequence

    a_gates_off_stop: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state != ST_RUN) |=> (gate == '0))
        else $error("gate on outside run state");
    a_run_entry_cause: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (state == ST_RUN) |-> $past(run_input_pin) &&
        ($past(speed_sense_channel) >= RUN_CODE))
        else $error("running without run input or setpoint");
    a_fault_forces_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
        fault_now |=> (state == ST_FAULT) && fault_flag ##1 (gate == '0))
        else $error("trip did not stop the drive");
    a_order_forward: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_step_fwd |=> step == (($past(step) == 2'h2) ? 2'h0
                                : $past(step) + 2'h1))
        else $error("forward step order wrong");
    a_order_reverse: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_step_rev |=> step == (($past(step) == 2'h0) ? 2'h2
                                : $past(step) - 2'h1))
        else $error("reverse step order wrong");
    a_ov_hysteresis: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ov_trip && (bus_volt_code >= OV_RELEASE_CODE) |=> ov_trip)
        else $error("over-voltage released above release level");
    a_sc_trip_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (phase_current_code > SC_CODE) |=> sc_trip ##1 fault_flag)
        else $error("short circuit not tripped");
    a_cbc_ends_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cbc_over && !period_start |=> !pwm_on)
        else $error("pulse continued after current limit");
    a_ot_trip_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (module_temp_code >= OT_CODE) |=> ot_trip)
        else $error("over-temperature not tripped");
    a_period_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
        period_start |=> (cnt == '0) ##1 (cnt == CW'(1)))
        else $error("carrier did not wrap at period end");

endmodule : mpwm_top

// >>> mpwm_pkg.sv
// Shared constants, types and the register map of the motor PWM block.
// Assumes a 200 MHz system clock and pre-sampled converter codes.
package mpwm_pkg;

    // System clock
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned CLK_PERIOD_NS = 5;

    // PWM carrier, chosen in the middle of the 15 to 16 kHz band
    localparam int unsigned PWM_FREQ_HZ = 15_500;
    localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;

    // Dead time, a least time, so it rounds up
    localparam int unsigned DEAD_TIME_NS = 2000;
    localparam int unsigned DEAD_CYC =
        (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Converter code widths
    localparam int unsigned ADC_W = 12;

    // Speed setpoint: full scale 4000 mV over 4096 codes
    localparam int unsigned SPEED_FULL_MV = 4000;
    localparam int unsigned RUN_MV = 400;
    localparam logic [11:0] RUN_CODE =
        12'((RUN_MV * 4096) / SPEED_FULL_MV);

    // Bus voltage code is 1 V per count
    localparam logic [11:0] OV_TRIP_CODE = 12'h1B8;
    localparam logic [11:0] OV_RELEASE_CODE = 12'h17C;

    // Phase current code is 10 mA per count
    localparam logic [11:0] SC_CODE = 12'h0C8;
    localparam logic [11:0] CBC_CODE = 12'h096;

    // Module temperature code is 1 degree C per count
    localparam logic [11:0] OT_CODE = 12'h064;

    // Register byte offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_IRQ_STS = 5'h08;
    localparam logic [4:0] REG_IRQ_MASK = 5'h0C;
    localparam logic [4:0] REG_STEP_DIV = 5'h10;
    localparam logic [4:0] REG_DUTY = 5'h14;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [15:0] STEP_DIV_RST = 16'h0010;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // Interrupt bit positions
    localparam int unsigned IRQ_OV = 0;
    localparam int unsigned IRQ_SC = 1;
    localparam int unsigned IRQ_OT = 2;
    localparam int unsigned IRQ_CBC = 3;

    // Gate drive bundle, index 0 is U, 1 is V, 2 is W
    typedef struct packed {
        logic [2:0] hs;
        logic [2:0] ls;
    } mpwm_gate_type;

    // Drive state
    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_RUN = 3'b010,
        ST_FAULT = 3'b100
    } mpwm_state_type;

endpackage : mpwm_pkg

// >>> mpwm_phase.sv
// One phase leg: complementary high and low gates with dead time.
// Assumes drive enable and PWM request are synchronous to sys_clk.
module mpwm_phase
    import mpwm_pkg::*;
#(
    parameter int unsigned DEAD = DEAD_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic drive_en,   // Leg may conduct
    input wire logic pwm_on,     // High side wanted
    output logic hs,             // High-side gate
    output logic ls              // Low-side gate
);

    localparam int unsigned GW = $clog2(DEAD + 1);

    logic [GW-1:0] gap;          // Cycles with both gates off
    logic [GW-1:0] next_gap;
    logic next_hs;
    logic next_ls;
    logic gap_done;

    assign gap_done = (gap >= GW'(DEAD));

    // A side turns off at once; the other waits the whole gap.
    // The gap is also served after reset, trading a little start
    // delay for never relying on the prior gate history.
    always_comb begin
        next_hs = 1'b0;
        next_ls = 1'b0;
        if (drive_en) begin
            if (pwm_on) begin
                next_hs = !ls && (hs || gap_done);
            end else begin
                next_ls = !hs && (ls || gap_done);
            end
        end
        if (next_hs || next_ls) begin
            next_gap = '0;
        end else if (gap_done) begin
            next_gap = gap;
        end else begin
            next_gap = gap + GW'(1);
        end
    end

    // Registers only
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            hs <= 1'b0;
            ls <= 1'b0;
            gap <= '0;
        end else begin
            hs <= next_hs;
            ls <= next_ls;
            gap <= next_gap;
        end
    end

    a_dead_gap_hs: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(hs) |-> $past(gap) >= GW'(DEAD))
        else $error("high side rose before dead time");
    a_dead_gap_ls: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(ls) |-> $past(gap) >= GW'(DEAD))
        else $error("low side rose before dead time");
    a_leg_disabled: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !drive_en |=> !hs && !ls)
        else $error("gate on while leg disabled");

endmodule : mpwm_phase

// >>> mpwm_ipm_model.sv
// Behavioural model of the power module gate inputs on the far side.
// Assumes gate bits change only just after sys_clk rising edges.
module mpwm_ipm_model
    import mpwm_pkg::*;
(
    input wire logic sys_clk,
    input wire mpwm_gate_type gate,
    output logic [1:0] leg,   // Conducting leg, 3 while all off
    output int off_gap,       // All-off cycles before the last turn-on
    output int rise_gap,      // Cycles between two high-side rises
    output int n_short        // Cycles with both sides of a leg on
);
    int off_cnt;              // Running all-off count
    int hs_cnt;               // Running count since a high-side rise
    logic [2:0] hs_d;         // High sides one cycle ago

    initial begin
        off_cnt = 0;
        hs_cnt = 0;
        hs_d = 3'h0;
        leg = 2'h3;
        off_gap = 0;
        rise_gap = 0;
        n_short = 0;
    end

    // Watch every rising edge; a real module would be damaged by an overlap
    always @(posedge sys_clk) begin
        if ((gate.hs & gate.ls) != 3'h0) begin
            n_short <= n_short + 1;
        end
        if (gate == '0) begin
            off_cnt <= off_cnt + 1;
        end else begin
            if (off_cnt != 0) begin
                off_gap <= off_cnt;
            end
            off_cnt <= 0;
        end
        if ((gate.hs & ~hs_d) != 3'h0) begin
            rise_gap <= hs_cnt + 1;
            hs_cnt <= 0;
        end else begin
            hs_cnt <= hs_cnt + 1;
        end
        hs_d <= gate.hs;
        // Leg decode, U has priority if several conduct
        if ((gate.hs[0] | gate.ls[0]) == 1'b1) begin
            leg <= 2'h0;
        end else if ((gate.hs[1] | gate.ls[1]) == 1'b1) begin
            leg <= 2'h1;
        end else if ((gate.hs[2] | gate.ls[2]) == 1'b1) begin
            leg <= 2'h2;
        end else begin
            leg <= 2'h3;
        end
    end
endmodule : mpwm_ipm_model

// >>> tb_motor_pwm_run_dir_control.sv
// Self-checking bench for the three-phase PWM drive.
// Assumes a shortened carrier period; register reads go through a queue.
module tb_motor_pwm_run_dir_control
    import mpwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 1000;  // Short carrier keeps the run brief
    typedef struct {
        logic [31:0] val;
        logic [31:0] msk;
    } mpwm_note_type;

    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic run = 1'b0;
    logic dir = 1'b0;
    logic [11:0] speed = 12'h000;
    logic [11:0] volt = 12'h136;
    logic [11:0] curr = 12'h000;
    logic [11:0] temp = 12'h019;
    mpwm_gate_type gate;
    logic fault_flag;
    logic irq;
    logic [1:0] leg;
    int off_gap, rise_gap, n_short;
    int n_fail = 0;
    int n_compared = 0;
    int seed = 32'hA8B42280;
    mpwm_note_type notes[$];    // Expected read results, oldest first
    logic [11:0] spd;

    always #2.5 sys_clk = ~sys_clk;

    mpwm_top #(.PERIOD(PER)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .run_input_pin(run),
        .direction_input_pin(dir), .speed_sense_channel(speed),
        .bus_volt_code(volt), .phase_current_code(curr),
        .module_temp_code(temp), .gate(gate), .fault_flag(fault_flag),
        .irq(irq));

    mpwm_ipm_model ipm (.sys_clk(sys_clk), .gate(gate), .leg(leg),
        .off_gap(off_gap), .rise_gap(rise_gap), .n_short(n_short));

    task automatic report_and_stop();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // Compare task for flags and counts seen at the pins
    task automatic cmp(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : cmp

    // Compare task for register reads, fed by the monitor below
    task automatic cmp_reg(input logic [31:0] got, input mpwm_note_type n);
        n_compared++;
        if ((got & n.msk) !== n.val) begin
            n_fail++;
            $display("wrong value at %0t: read %h", $time, got);
        end
    endtask : cmp_reg

    // Monitor takes the oldest note when a read completes
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (notes.size() == 0) begin
                cmp(1'b0, "unexpected read");
            end else begin
                cmp_reg(avs_readdata, notes.pop_front());
            end
        end
    end

    // One bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && k < 50) begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 50) begin
            cmp(1'b0, "bus hang");
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] v,
                      input logic [31:0] m);
        notes.push_back('{val: v, msk: m});
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    // Four leg changes must follow the firing order for the direction
    task automatic order_check(input logic fwd);
        logic [1:0] cur;
        int k;
        k = 0;
        cyc(PER);
        while (leg === 2'h3 && k < 3 * PER) begin
            cyc(1);
            k++;
        end
        cur = leg;
        repeat (4) begin
            k = 0;
            while ((leg === 2'h3 || leg === cur) && k < 3 * PER) begin
                cyc(1);
                k++;
            end
            cmp(leg === (fwd ? (cur + 2'h1) % 3 : (cur + 2'h2) % 3),
                "leg order");
            cur = leg;
        end
    endtask : order_check

    // Watchdog sized well above the whole sequence
    initial begin
        cyc(90000);
        n_fail++;
        report_and_stop();
    end

    initial begin
        cyc(5);
        rst_b <= 1'b1;
        cyc(1);
        rd(REG_CTRL, 32'h1, 32'hFFFF_FFFF);
        rd(REG_IRQ_MASK, 32'h0, 32'hF);
        rd(REG_STEP_DIV, 32'h10, 32'hFFFF);
        rd(5'h18, 32'h0, 32'hFFFF_FFFF);
        rd(REG_STATUS, 32'h08, 32'h3F);
        // Just under the run threshold nothing may conduct
        speed <= RUN_CODE - 12'h001;
        run <= 1'b1;
        dir <= 1'b1;
        cyc(2 * PER);
        cmp(gate === '0, "ran below threshold");
        rd(REG_STATUS, 32'h0B, 32'h3F);
        bus(1'b1, REG_STEP_DIV, 32'h0);
        speed <= RUN_CODE;
        order_check(1'b1);
        cmp(off_gap >= DEAD_CYC && off_gap <= 500, "dead time");
        dir <= 1'b0;
        order_check(1'b0);
        rd(REG_STATUS, 32'h11, 32'h3F);
        // Hold one leg and compare duty and carrier
        bus(1'b1, REG_STEP_DIV, 32'hFFFF);
        repeat (3) begin
            spd = 12'(2048 + ({$random(seed)} % 800));
            speed <= spd;
            // Duty lands at the next wrap and the period after it still
            // shows the old falling edge, so two steady rises need four
            cyc(4 * PER);
            rd(REG_DUTY, (32'(spd) * PER) >> 12, 32'hFFFF_FFFF);
            cmp(rise_gap === PER, "carrier period");
        end
        cmp(n_short === 0, "leg overlap");
        // Current limit must end a running high-side pulse
        while (gate.hs === 3'h0) begin
            cyc(1);
        end
        curr <= 12'h097;
        cyc(3);
        cmp(gate.hs === 3'h0, "pulse not cut");
        curr <= 12'h000;
        volt <= 12'h1B9;
        cyc(4);
        cmp(fault_flag === 1'b1 && gate === '0, "ov trip");
        volt <= 12'h17C;
        cyc(4);
        cmp(fault_flag === 1'b1, "ov released early");
        volt <= 12'h17B;
        cyc(4);
        cmp(fault_flag === 1'b0, "ov held");
        temp <= 12'h063;
        cyc(4);
        cmp(fault_flag === 1'b0, "ot early");
        temp <= 12'h064;
        cyc(4);
        cmp(fault_flag === 1'b1 && gate === '0, "ot trip");
        temp <= 12'h019;
        curr <= 12'h0C9;
        cyc(4);
        cmp(fault_flag === 1'b1, "sc trip");
        curr <= 12'h000;
        cyc(4);
        cmp(fault_flag === 1'b1 && irq === 1'b0, "sc latch");
        run <= 1'b0;
        cyc(4);
        cmp(fault_flag === 1'b0 && gate === '0, "stop");
        // Interrupt: masked, unmasked, then cleared
        rd(REG_IRQ_STS, 32'hF, 32'hF);
        bus(1'b1, REG_IRQ_MASK, 32'hF);
        cyc(2);
        cmp(irq === 1'b1, "irq unmasked");
        bus(1'b1, REG_IRQ_STS, 32'hF);
        cyc(2);
        cmp(irq === 1'b0, "irq cleared");
        rd(REG_IRQ_STS, 32'h0, 32'hF);
        cyc(2);
        report_and_stop();
    end
endmodule : tb_motor_pwm_run_dir_control
